// *** bench/logic_swap_instr_datapath_bench.sv ***
`timescale 1ns/1ps
module logic_swap_instr_datapath_bench;
   // ------------------------------------------------------------
   // signals and short operation names
   // ------------------------------------------------------------
   localparam lsid_pkg::lsid_op_t op_or = lsid_pkg::LSID_OP_OR_REG;
   localparam lsid_pkg::lsid_op_t op_sw = lsid_pkg::LSID_OP_SWAP;
   localparam lsid_pkg::lsid_op_t op_xl = lsid_pkg::LSID_OP_XOR_LIT;
   localparam lsid_pkg::lsid_op_t op_dr = lsid_pkg::LSID_OP_DIR;
   localparam lsid_pkg::lsid_op_t op_xr = lsid_pkg::LSID_OP_XOR_REG;
   logic sys_clk;
   logic rst;
   logic op_valid;
   lsid_pkg::lsid_op_t op_code;
   logic [6:0] op_addr;
   logic op_dest;
   logic [7:0] op_literal;
   logic [7:0] file_rdata;
   logic [6:0] file_addr;
   logic file_we;
   logic [7:0] file_wdata;
   logic [7:0] acc;
   logic zero_flag;
   logic [7:0] dir_a;
   logic [7:0] dir_b;
   logic [7:0] dir_c;
   int errors = 0; // mismatches
   int tests_run = 0; // comparisons
   int cycles = 0; // hang guard

   lsid_datapath uut (.sys_clk(sys_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
      .op_addr(op_addr), .op_dest(op_dest), .op_literal(op_literal), .file_rdata(file_rdata),
      .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata), .acc(acc),
      .zero_flag(zero_flag), .port_a_direction(dir_a), .port_b_direction(dir_b),
      .port_c_direction(dir_c));
   lsid_file_model mem_model (.sys_clk(sys_clk), .file_addr(file_addr), .file_we(file_we),
      .file_wdata(file_wdata), .file_rdata(file_rdata));

   // ------------------------------------------------------------
   // clock and hang guard
   // ------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // whole run needs under 100 cycles; 3000 leaves ample margin
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one instruction, then one idle cycle so a write-back never races a read
   task automatic step(input lsid_pkg::lsid_op_t c, input logic [6:0] a, input logic d,
      input logic [7:0] k, input logic [7:0] ea, input logic ez, input logic ew,
      input logic [7:0] ed);
      @(negedge sys_clk);
      op_valid = 1'b1;
      op_code = c;
      op_addr = a;
      op_dest = d;
      op_literal = k;
      @(negedge sys_clk);
      op_valid = 1'b0;
      op_code = lsid_pkg::LSID_OP_NONE;
      check("acc", acc, ea);
      check("zero_flag", {7'h00, zero_flag}, {7'h00, ez});
      check("file_we", {7'h00, file_we}, {7'h00, ew});
      if (ew) begin
         check("file_addr", {1'b0, file_addr}, {1'b0, a});
         check("file_wdata", file_wdata, ed);
      end
   endtask
   task automatic dirs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      check("dir_a", dir_a, a);
      check("dir_b", dir_b, b);
      check("dir_c", dir_c, c);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios, each judged by the step calls, the direction load also by the dirs calls
   // ------------------------------------------------------------
   task automatic t_xor_lit();
      step(op_xl, 7'h00, 1'b1, 8'ha5, 8'ha5, 1'b0, 1'b0, 8'h00);
      step(op_xl, 7'h00, 1'b0, 8'ha5, 8'h00, 1'b1, 1'b0, 8'h00);
      $display("xor literal done");
   endtask
   task automatic t_or_reg();
      mem_model.mem[127] = 8'h00;
      mem_model.mem[16] = 8'h3c;
      mem_model.mem[17] = 8'h83;
      step(op_or, 7'h7f, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
      step(op_or, 7'h10, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1, 8'h3c);
      // nonzero accumulator so xor or a plain copy would differ from or
      step(op_xl, 7'h00, 1'b0, 8'h41, 8'h41, 1'b0, 1'b0, 8'h00);
      step(op_or, 7'h11, 1'b0, 8'h00, 8'hc3, 1'b0, 1'b0, 8'h00);
      step(op_xl, 7'h00, 1'b0, 8'hc3, 8'h00, 1'b1, 1'b0, 8'h00);
      $display("or register done");
   endtask
   // zero set first so a flag change by the swap would show
   task automatic t_swap();
      mem_model.mem[32] = 8'h12;
      mem_model.mem[33] = 8'hab;
      step(op_xl, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
      step(op_sw, 7'h20, 1'b0, 8'h00, 8'h21, 1'b1, 1'b0, 8'h00);
      step(op_sw, 7'h21, 1'b1, 8'h00, 8'h21, 1'b1, 1'b1, 8'hba);
      $display("swap done");
   endtask
   task automatic t_xor_reg();
      mem_model.mem[64] = 8'h21;
      mem_model.mem[0] = 8'h5a;
      step(op_xr, 7'h40, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
      step(op_xr, 7'h00, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1, 8'h5a);
      $display("xor register done");
   endtask
   // select 4 lies outside 5..7 and must leave every bank alone
   task automatic t_dir();
      step(op_xl, 7'h00, 1'b0, 8'h11, 8'h11, 1'b0, 1'b0, 8'h00);
      step(op_dr, 7'h05, 1'b0, 8'h00, 8'h11, 1'b0, 1'b0, 8'h00);
      dirs(8'h11, 8'hff, 8'hff);
      step(op_xl, 7'h00, 1'b0, 8'h11, 8'h00, 1'b1, 1'b0, 8'h00);
      step(op_dr, 7'h06, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
      step(op_xl, 7'h00, 1'b0, 8'h66, 8'h66, 1'b0, 1'b0, 8'h00);
      step(op_dr, 7'h07, 1'b0, 8'h00, 8'h66, 1'b0, 1'b0, 8'h00);
      step(op_dr, 7'h04, 1'b0, 8'h00, 8'h66, 1'b0, 1'b0, 8'h00);
      dirs(8'h11, 8'h00, 8'h66);
      $display("direction load done");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      op_valid = 1'b0;
      op_code = lsid_pkg::LSID_OP_NONE;
      op_addr = 7'h00;
      op_dest = 1'b0;
      op_literal = 8'h00;
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      check("acc", acc, lsid_pkg::LSID_ACC_RST);
      dirs(lsid_pkg::LSID_DIR_RST, lsid_pkg::LSID_DIR_RST, lsid_pkg::LSID_DIR_RST);
      t_xor_lit();
      t_or_reg();
      t_swap();
      t_xor_reg();
      t_dir();
      print_verdict();
   end
endmodule

// *** bench/lsid_file_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// data memory file seen by the datapath
// ------------------------------------------------------------
module lsid_file_model (
   input wire logic sys_clk,
   input wire logic [6:0] file_addr,
   input wire logic file_we,
   input wire logic [7:0] file_wdata,
   output logic [7:0] file_rdata
);
   logic [7:0] mem [0:127]; // 128 file registers, loaded by the bench
   // read is combinational, as the datapath samples it on the taking edge
   assign file_rdata = mem[file_addr];
   // write-back lands on the edge that ends the write pulse
   always @(posedge sys_clk) begin
      if (file_we) begin
         mem[file_addr] <= file_wdata;
      end
   end
endmodule

// *** rtl/lsid_datapath.sv ***
`timescale 1ns/1ps
module lsid_datapath (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic op_valid,
   input wire lsid_pkg::lsid_op_t op_code,
   input wire logic [6:0] op_addr,
   input wire logic op_dest,
   input wire logic [7:0] op_literal,
   input wire logic [7:0] file_rdata,
   output logic [6:0] file_addr,
   output logic file_we,
   output logic [7:0] file_wdata,
   output logic [7:0] acc,
   output logic zero_flag,
   output logic [7:0] port_a_direction,
   output logic [7:0] port_b_direction,
   output logic [7:0] port_c_direction
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] acc_reg, acc_next; // working accumulator
   logic zero_reg, zero_next; // zero flag
   logic we_reg, we_next; // file write strobe
   logic [7:0] wd_reg, wd_next; // file write data
   logic [6:0] wa_reg, wa_next; // file write address
   logic [7:0] result; // combinational alu result
   logic to_acc; // result goes to accumulator
   logic sets_zero; // op updates zero flag

   lsid_dir_if dir ();

   function automatic logic is_zero(input logic [7:0] v);
      is_zero = (v == 8'h00);
   endfunction

   // ------------------------------------------------------------
   // alu
   // ------------------------------------------------------------
   // one result bus for every op; the decode below only picks the source,
   // so the write-back and the accumulator always see the same value
   always_comb begin
      result = acc_reg;
      to_acc = 1'b0;
      sets_zero = 1'b0;
      case (op_code)
         lsid_pkg::LSID_OP_OR_REG: begin
            result = acc_reg | file_rdata;
            to_acc = (op_dest == lsid_pkg::LSID_DEST_ACC);
            sets_zero = 1'b1;
         end
         lsid_pkg::LSID_OP_SWAP: begin
            result = {file_rdata[3:0], file_rdata[7:4]};
            to_acc = (op_dest == lsid_pkg::LSID_DEST_ACC);
         end
         lsid_pkg::LSID_OP_XOR_LIT: begin
            result = acc_reg ^ op_literal;
            to_acc = 1'b1; // literal op has no file destination
            sets_zero = 1'b1;
         end
         lsid_pkg::LSID_OP_XOR_REG: begin
            result = acc_reg ^ file_rdata;
            to_acc = (op_dest == lsid_pkg::LSID_DEST_ACC);
            sets_zero = 1'b1;
         end
         default: result = acc_reg; // direction load and idle
      endcase
   end

   // ------------------------------------------------------------
   // next state of accumulator, flag and file write
   // ------------------------------------------------------------
   // write data and address hold their last value between writes, which
   // costs nothing and keeps the file side quiet while file_we is low
   always_comb begin
      acc_next = acc_reg;
      zero_next = zero_reg;
      we_next = 1'b0;
      wd_next = wd_reg;
      wa_next = wa_reg;
      if (op_valid) begin
         if (to_acc) begin
            acc_next = result;
         end else if (op_code == lsid_pkg::LSID_OP_OR_REG ||
            op_code == lsid_pkg::LSID_OP_SWAP ||
            op_code == lsid_pkg::LSID_OP_XOR_REG) begin
            // write back one cycle later so read data is not disturbed
            we_next = 1'b1;
            wd_next = result;
            wa_next = op_addr;
         end
         if (sets_zero) begin
            zero_next = is_zero(result);
         end
      end
   end

   // register stage
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acc_reg <= lsid_pkg::LSID_ACC_RST;
         zero_reg <= lsid_pkg::LSID_ZERO_RST;
         we_reg <= 1'b0;
         wd_reg <= 8'h00;
         wa_reg <= 7'h00;
      end else begin
         acc_reg <= acc_next;
         zero_reg <= zero_next;
         we_reg <= we_next;
         wd_reg <= wd_next;
         wa_reg <= wa_next;
      end
   end

   // ------------------------------------------------------------
   // direction bank hookup
   // ------------------------------------------------------------
   assign dir.load = op_valid && (op_code == lsid_pkg::LSID_OP_DIR);
   assign dir.sel = op_addr;
   assign dir.data = acc_reg;

   lsid_dir_bank u_bank (
      .sys_clk(sys_clk),
      .rst(rst),
      .dir(dir)
   );

   // outputs: read address follows the operand, write address is held
   // the address is shared by read and write, so an op that reads the file
   // in a write-back cycle would see the written register, not its own;
   // the decoder must leave one idle slot after a write to the file
   // (limitation traded for a single-port data memory)
   assign file_addr = we_reg ? wa_reg : op_addr;
   assign file_we = we_reg;
   assign file_wdata = wd_reg;
   assign acc = acc_reg;
   assign zero_flag = zero_reg;
   assign port_a_direction = dir.port_a;
   assign port_b_direction = dir.port_b;
   assign port_c_direction = dir.port_c;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   or_to_acc_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_OR_REG && !op_dest
      |=> acc == ($past(acc) | $past(file_rdata)) && !file_we)
      else $error("or to accumulator wrong");
   or_to_file_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_OR_REG && op_dest
      |=> file_we && file_wdata == ($past(acc) | $past(file_rdata))
      && acc == $past(acc))
      else $error("or to file wrong");
   swap_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_SWAP
      |=> zero_flag == $past(zero_flag))
      else $error("swap changed zero flag");
   swap_value_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_SWAP && op_dest
      |=> file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
      else $error("swap data wrong");
   xor_lit_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_XOR_LIT
      |=> acc == ($past(acc) ^ $past(op_literal)) && !file_we)
      else $error("xor literal wrong");
   dir_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_DIR && op_addr == lsid_pkg::LSID_SEL_PORT_A
      |=> port_a_direction == $past(acc) && zero_flag == $past(zero_flag))
      else $error("direction load wrong");
   xor_reg_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_XOR_REG && op_dest
      |=> file_we && file_wdata == ($past(acc) ^ $past(file_rdata))
      ##1 !file_we)
      else $error("xor to file wrong");
   zero_track_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_XOR_LIT
      |=> zero_flag == (acc == 8'h00))
      else $error("zero flag mismatch");

   // ------------------------------------------------------------
   // checks on the accumulator paths, the zero flag, the port c direction and the write-back address
   // ------------------------------------------------------------
   // expected values are rebuilt from the sampled operands, not from the
   // alu result, so a broken decode cannot agree with itself
   swap_to_acc_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_SWAP && !op_dest
      |=> acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && !file_we)
      else $error("swap to accumulator wrong");
   xor_to_acc_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_XOR_REG && !op_dest
      |=> acc == ($past(acc) ^ $past(file_rdata)) && !file_we)
      else $error("xor to accumulator wrong");
   or_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_OR_REG
      |=> zero_flag == (($past(acc) | $past(file_rdata)) == 8'h00))
      else $error("zero flag after or wrong");
   xor_reg_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_XOR_REG
      |=> zero_flag == (($past(acc) ^ $past(file_rdata)) == 8'h00))
      else $error("zero flag after xor wrong");
   dir_keeps_acc_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_DIR
      |=> acc == $past(acc) && !file_we)
      else $error("direction load disturbed accumulator");
   dir_port_c_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_code == lsid_pkg::LSID_OP_DIR
      && op_addr == lsid_pkg::LSID_SEL_PORT_C
      |=> port_c_direction == $past(acc))
      else $error("port c direction not loaded");
   write_addr_a: assert property (@(posedge sys_clk) disable iff (rst)
      op_valid && op_dest && (op_code == lsid_pkg::LSID_OP_OR_REG
      || op_code == lsid_pkg::LSID_OP_SWAP
      || op_code == lsid_pkg::LSID_OP_XOR_REG)
      |=> file_addr == $past(op_addr))
      else $error("write back address wrong");
endmodule

// *** rtl/lsid_dir_bank.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// port direction registers
// ------------------------------------------------------------
module lsid_dir_bank (
   input wire logic sys_clk,
   input wire logic rst,
   lsid_dir_if.bank dir
);
   logic [7:0] a_reg, a_next; // port a direction
   logic [7:0] b_reg, b_next; // port b direction
   logic [7:0] c_reg, c_next; // port c direction

   // select one register by operand; other operand values load nothing
   always_comb begin
      a_next = a_reg;
      b_next = b_reg;
      c_next = c_reg;
      if (dir.load) begin
         case (dir.sel)
            lsid_pkg::LSID_SEL_PORT_A: a_next = dir.data;
            lsid_pkg::LSID_SEL_PORT_B: b_next = dir.data;
            lsid_pkg::LSID_SEL_PORT_C: c_next = dir.data;
            default: a_next = a_reg; // out of range operand ignored
         endcase
      end
   end

   // register stage
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         a_reg <= lsid_pkg::LSID_DIR_RST;
         b_reg <= lsid_pkg::LSID_DIR_RST;
         c_reg <= lsid_pkg::LSID_DIR_RST;
      end else begin
         a_reg <= a_next;
         b_reg <= b_next;
         c_reg <= c_next;
      end
   end

   assign dir.port_a = a_reg;
   assign dir.port_b = b_reg;
   assign dir.port_c = c_reg;

   port_b_load_a: assert property (@(posedge sys_clk) disable iff (rst)
      dir.load && dir.sel == lsid_pkg::LSID_SEL_PORT_B |=> b_reg == $past(dir.data)
      && a_reg == $past(a_reg))
      else $error("port b direction not loaded");
endmodule

// *** rtl/lsid_dir_if.sv ***
`timescale 1ns/1ps
// direction-register load path between datapath and direction bank
interface lsid_dir_if;
   logic load; // one-cycle load strobe
   logic [6:0] sel; // port select operand
   logic [7:0] data; // value to store
   logic [7:0] port_a; // stored directions
   logic [7:0] port_b;
   logic [7:0] port_c;
   modport src (output load, output sel, output data, input port_a, input port_b,
      input port_c);
   modport bank (input load, input sel, input data, output port_a, output port_b,
      output port_c);
endinterface

// *** rtl/lsid_pkg.sv ***
package lsid_pkg;
   // ------------------------------------------------------------
   // operation codes from the decoder
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      LSID_OP_NONE = 3'h0, // idle cycle
      LSID_OP_OR_REG = 3'h1, // or_acc_with_reg
      LSID_OP_SWAP = 3'h2, // nibble_exchange_reg
      LSID_OP_XOR_LIT = 3'h3, // xor_acc_with_literal
      LSID_OP_DIR = 3'h4, // load_port_direction
      LSID_OP_XOR_REG = 3'h5 // xor_acc_with_reg
   } lsid_op_t;

   // ------------------------------------------------------------
   // reset values and operand codes
   // ------------------------------------------------------------
   localparam logic [7:0] LSID_ACC_RST = 8'h00; // accumulator after reset
   localparam logic [7:0] LSID_DIR_RST = 8'hff; // all pins input after reset
   localparam logic LSID_ZERO_RST = 1'b0; // zero flag after reset
   localparam logic [6:0] LSID_SEL_PORT_A = 7'h05; // port a direction select
   localparam logic [6:0] LSID_SEL_PORT_B = 7'h06; // port b direction select
   localparam logic [6:0] LSID_SEL_PORT_C = 7'h07; // port c direction select
   localparam logic LSID_DEST_ACC = 1'b0; // destination bit: accumulator
endpackage
